// *** hdl/cmp_mux_params.svh ***
// constants for the comparator input select block
// assumes inclusion by the package and the module of this block
//
// Function
// - bits 7:4 pick comparator0 negative input among odd port bits
// - negative codes 1001..1011 pick port2 bits 3,5,7 (large packages)
// - bits 3:0 pick comparator0 positive input among even port bits
// - positive codes 1001..1011 pick port2 bits 2,4,6 (large packages)
// - comparator1 has its own identical, independent selector register
// - comparator0 selector is read/write at address 0x9c, page 0x00
// - comparator1 selector is read/write at address 0x9f, page 0x00
// - both selectors may choose the same pins at once
`ifndef CMP_MUX_PARAMS_SVH
`define CMP_MUX_PARAMS_SVH
// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define CMP0_SEL_ADDR   8'h9c
`define CMP1_SEL_ADDR   8'h9f
`define CMP_SEL_PAGE    8'h00
`define CMP_SEL_RESET   8'h77
// ----------------------------------------------------------------------
// field positions and codes
// ----------------------------------------------------------------------
`define NEG_MSB         7
`define NEG_LSB         4
`define POS_MSB         3
`define POS_LSB         0
`define CODE_LAST_PIN   4'hb
`define CODE_SMALL_LAST 4'h8
`endif

// *** hdl/cmp_mux_pkg.sv ***
// types for the comparator input select block
// assumes the params header sits beside it on the include path
`default_nettype none
`include "cmp_mux_params.svh"
package cmp_mux_pkg;
   // one-hot pin select toward the analog switches
   typedef struct packed {
      logic [11:0] neg_pin;   // odd pins p0.1..p2.7
      logic [11:0] pos_pin;   // even pins p0.0..p2.6
   } cmp_route_type;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [7:0]  page;
      logic [7:0]  wdata;
   } sfr_req_type;

   typedef struct packed {
      logic [7:0]    sel0_r;
      logic [7:0]    sel1_r;
      logic [7:0]    rdata_r;
      cmp_route_type route0_r;
      cmp_route_type route1_r;
   } cmp_state_type;
endpackage : cmp_mux_pkg
`default_nettype wire

// *** hdl/comparator_input_select.sv ***
// selector registers routing port pins to two comparator inputs
// assumes the cpu drives sfr requests synchronously on clock_i
`timescale 1ns/10ps
`default_nettype none
`include "cmp_mux_params.svh"
module comparator_input_select #(
   parameter bit LARGE_PACKAGE = 1'b1   // 40 or 32 pin variant
) (
   input  wire logic                   clock_i,
   input  wire logic                   rst_n_i,
   input  wire logic                   clk_en_i,
   input  wire cmp_mux_pkg::sfr_req_type sfr_i,
   output logic [7:0]                  rdata_o,
   output var  cmp_mux_pkg::cmp_route_type cmp0_route_o,
   output var  cmp_mux_pkg::cmp_route_type cmp1_route_o
);
   import cmp_mux_pkg::*;

   cmp_state_type st_r;
   cmp_state_type st_nxt;
   logic          hit0;
   logic          hit1;

   // ------------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------------
   // one 4-bit code to a one-hot pin; codes past the package fall to none
   function automatic logic [11:0] pin_onehot(input logic [3:0] code);
      logic [11:0] v;
      logic [3:0]  last;
      v = 12'h000;
      last = LARGE_PACKAGE ? `CODE_LAST_PIN : `CODE_SMALL_LAST;
      if (code <= last) begin
         v[code] = 1'b1; // codes 1100..1111 stay none
      end
      return v;
   endfunction : pin_onehot

   function automatic cmp_route_type route_of(input logic [7:0] sel);
      cmp_route_type r;
      r.neg_pin = pin_onehot(sel[`NEG_MSB:`NEG_LSB]);
      r.pos_pin = pin_onehot(sel[`POS_MSB:`POS_LSB]);
      return r;
   endfunction : route_of

   // ------------------------------------------------------------------
   // register access and routing
   // ------------------------------------------------------------------
   // page must match too; other pages alias different registers
   assign hit0 = (sfr_i.addr == `CMP0_SEL_ADDR)
                 && (sfr_i.page == `CMP_SEL_PAGE);
   assign hit1 = (sfr_i.addr == `CMP1_SEL_ADDR)
                 && (sfr_i.page == `CMP_SEL_PAGE);

   // next state; routes follow the written value, not the old one
   always_comb begin
      st_nxt = st_r;
      if (sfr_i.wr && hit0) begin
         st_nxt.sel0_r = sfr_i.wdata;
      end
      if (sfr_i.wr && hit1) begin
         st_nxt.sel1_r = sfr_i.wdata;
      end
      if (sfr_i.rd) begin
         st_nxt.rdata_r = hit0 ? st_r.sel0_r :
                          hit1 ? st_r.sel1_r : 8'h00;
      end
      // separate decoders: same pin may go to both comparators
      st_nxt.route0_r = route_of(st_nxt.sel0_r);
      st_nxt.route1_r = route_of(st_nxt.sel1_r);
   end

   // state register with enable freeze
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         st_r.sel0_r   <= `CMP_SEL_RESET;
         st_r.sel1_r   <= `CMP_SEL_RESET;
         st_r.rdata_r  <= 8'h00;
         st_r.route0_r <= route_of(`CMP_SEL_RESET);
         st_r.route1_r <= route_of(`CMP_SEL_RESET);
      end else if (clk_en_i) begin
         st_r <= st_nxt;
      end
   end

   assign rdata_o      = st_r.rdata_r;
   assign cmp0_route_o = st_r.route0_r;
   assign cmp1_route_o = st_r.route1_r;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   property p_wr0_route;
      @(posedge clock_i) disable iff (!rst_n_i)
      (clk_en_i && sfr_i.wr && hit0)
         |=> cmp0_route_o == route_of($past(sfr_i.wdata));
   endproperty
   a_wr0_route: assert property (p_wr0_route)
      else $error("comparator0 route not updated after write");

   property p_wr1_route;
      @(posedge clock_i) disable iff (!rst_n_i)
      (clk_en_i && sfr_i.wr && hit1)
         |=> cmp1_route_o == route_of($past(sfr_i.wdata));
   endproperty
   a_wr1_route: assert property (p_wr1_route)
      else $error("comparator1 route not updated after write");

   property p_indep;
      @(posedge clock_i) disable iff (!rst_n_i)
      (clk_en_i && sfr_i.wr && hit0) |=> $stable(cmp1_route_o);
   endproperty
   a_indep: assert property (p_indep)
      else $error("comparator1 route moved on comparator0 write");

   property p_none_neg;
      @(posedge clock_i) disable iff (!rst_n_i)
      (st_r.sel0_r[7:6] == 2'b11) |-> cmp0_route_o.neg_pin == 12'h000;
   endproperty
   a_none_neg: assert property (p_none_neg)
      else $error("negative none code drives a pin");

   property p_none_pos;
      @(posedge clock_i) disable iff (!rst_n_i)
      (st_r.sel0_r[3:2] == 2'b11) |-> cmp0_route_o.pos_pin == 12'h000;
   endproperty
   a_none_pos: assert property (p_none_pos)
      else $error("positive none code drives a pin");

   property p_neg_hi;
      @(posedge clock_i) disable iff (!rst_n_i)
      (LARGE_PACKAGE && st_r.sel0_r[7:4] == 4'hb)
         |-> cmp0_route_o.neg_pin == 12'h800;
   endproperty
   a_neg_hi: assert property (p_neg_hi)
      else $error("negative code 1011 not on port2 bit 7");

   property p_pos_hi;
      @(posedge clock_i) disable iff (!rst_n_i)
      (LARGE_PACKAGE && st_r.sel0_r[3:0] == 4'h9)
         |-> cmp0_route_o.pos_pin == 12'h200;
   endproperty
   a_pos_hi: assert property (p_pos_hi)
      else $error("positive code 1001 not on port2 bit 2");

   property p_read0;
      @(posedge clock_i) disable iff (!rst_n_i)
      (clk_en_i && sfr_i.rd && hit0) |=> rdata_o == $past(st_r.sel0_r);
   endproperty
   a_read0: assert property (p_read0)
      else $error("comparator0 selector read wrong");

   property p_same;
      @(posedge clock_i) disable iff (!rst_n_i)
      (st_r.sel0_r == st_r.sel1_r) |-> cmp0_route_o == cmp1_route_o;
   endproperty
   a_same: assert property (p_same)
      else $error("equal selectors give different routes");

   // comparator1 read path mirrors comparator0
   property p_read1;
      @(posedge clock_i) disable iff (!rst_n_i)
      (clk_en_i && sfr_i.rd && hit1) |=> rdata_o == $past(st_r.sel1_r);
   endproperty
   a_read1: assert property (p_read1)
      else $error("comparator1 selector read wrong");

   // any other address or page reads as zero
   property p_read_other;
      @(posedge clock_i) disable iff (!rst_n_i)
      (clk_en_i && sfr_i.rd && !hit0 && !hit1) |=> rdata_o == 8'h00;
   endproperty
   a_read_other: assert property (p_read_other)
      else $error("unmapped read returned nonzero data");

   // the full byte is kept, so a read returns exactly what was written
   property p_wr1_store;
      @(posedge clock_i) disable iff (!rst_n_i)
      (clk_en_i && sfr_i.wr && hit1) |=> st_r.sel1_r == $past(sfr_i.wdata);
   endproperty
   a_wr1_store: assert property (p_wr1_store)
      else $error("comparator1 selector did not keep written byte");

   // enable low freezes routes and read data; a stalled cpu sees no change
   property p_freeze;
      @(posedge clock_i) disable iff (!rst_n_i)
      !clk_en_i |=> $stable(cmp0_route_o) && $stable(cmp1_route_o)
         && $stable(rdata_o);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("state moved while clock enable was low");

   // at most one switch per comparator input, or two pins would short
   property p_onehot;
      @(posedge clock_i) disable iff (!rst_n_i)
      $onehot0(cmp0_route_o.neg_pin) && $onehot0(cmp0_route_o.pos_pin)
         && $onehot0(cmp1_route_o.neg_pin) && $onehot0(cmp1_route_o.pos_pin);
   endproperty
   a_onehot: assert property (p_onehot)
      else $error("more than one pin switched onto a comparator input");

   // small packages: codes 1001..1011 name missing pins, so nothing driven
   property p_small_none;
      @(posedge clock_i) disable iff (!rst_n_i)
      (!LARGE_PACKAGE && st_r.sel0_r[7:4] > 4'h8 && st_r.sel0_r[7:4] < 4'hc)
         |-> cmp0_route_o.neg_pin == 12'h000;
   endproperty
   a_small_none: assert property (p_small_none)
      else $error("missing pin switched on a small package");

   // first edge after reset: both selectors hold 0111_0111
   property p_reset_route;
      @(posedge clock_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> cmp0_route_o == cmp1_route_o
         && cmp0_route_o.neg_pin == 12'h080
         && cmp0_route_o.pos_pin == 12'h080 && rdata_o == 8'h00;
   endproperty
   a_reset_route: assert property (p_reset_route)
      else $error("routes after reset not on port1 bit 7 and bit 6");

   // comparator1 decodes its none codes the same way
   property p_none1;
      @(posedge clock_i) disable iff (!rst_n_i)
      (st_r.sel1_r[7:6] == 2'b11) |-> cmp1_route_o.neg_pin == 12'h000;
   endproperty
   a_none1: assert property (p_none1)
      else $error("comparator1 negative none code drives a pin");
endmodule : comparator_input_select
`default_nettype wire

// *** tb/cmp_pin_switch.sv ***
// model of the analog switches fed by one comparator route
// assumes one-hot routes, all zero meaning unconnected
`timescale 1ns/10ps
`default_nettype none
module cmp_pin_switch (
   input  wire cmp_mux_pkg::cmp_route_type route_i,
   output logic [3:0]                      neg_idx_o,
   output logic [3:0]                      pos_idx_o
);
   import cmp_mux_pkg::*;
   // two hot bits would short two pins, so that reads as none (4'hf)
   always_comb begin
      neg_idx_o = 4'hf;
      pos_idx_o = 4'hf;
      for (int k = 0; k < 12; k++) begin
         if (route_i.neg_pin == 12'h001 << k) neg_idx_o = 4'(k);
         if (route_i.pos_pin == 12'h001 << k) pos_idx_o = 4'(k);
      end
   end
endmodule : cmp_pin_switch
`default_nettype wire

// *** tb/test_comparator_input_select.sv ***
// bench for the comparator input select block
// assumes package, design and switch model are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "cmp_mux_params.svh"
module test_comparator_input_select;
   import cmp_mux_pkg::*;
   logic          clock_i, rst_n_i, clk_en_i;
   sfr_req_type   sfr_i;
   logic [7:0]    rdata_o, s0, s1, last;
   cmp_route_type cmp0_route_o, cmp1_route_o;
   logic [3:0]    n0, p0, n1, p1;
   cmp_route_type small0_route, small1_route;
   logic [119:0]  q[$];
   int            miscompares = 0, n_compared = 0, k;

   comparator_input_select uut (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .clk_en_i(clk_en_i), .sfr_i(sfr_i), .rdata_o(rdata_o),
      .cmp0_route_o(cmp0_route_o), .cmp1_route_o(cmp1_route_o));
   // small package copy: codes 1001..1011 must fall to none there
   comparator_input_select #(.LARGE_PACKAGE(1'b0)) uut_small (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
      .sfr_i(sfr_i), .rdata_o(),
      .cmp0_route_o(small0_route), .cmp1_route_o(small1_route));
   // both comparators may sit on one pin at once
   cmp_pin_switch sw0 (.route_i(cmp0_route_o), .neg_idx_o(n0),
      .pos_idx_o(p0));
   cmp_pin_switch sw1 (.route_i(cmp1_route_o), .neg_idx_o(n1),
      .pos_idx_o(p1));

   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end

   // expected one-hot route and switch index of one code; past lim: none
   function automatic logic [15:0] pin(input logic [3:0] c, lim);
      return (c <= lim) ? {12'h001 << c, c} : {12'h000, 4'hf};
   endfunction : pin

   // note layout matches the monitor's concatenation of outputs
   function automatic logic [119:0] note();
      logic [15:0] a, b, c, d, e, f, g, h;
      a = pin(s0[7:4], `CODE_LAST_PIN);
      b = pin(s0[3:0], `CODE_LAST_PIN);
      c = pin(s1[7:4], `CODE_LAST_PIN);
      d = pin(s1[3:0], `CODE_LAST_PIN);
      e = pin(s0[7:4], `CODE_SMALL_LAST);
      f = pin(s0[3:0], `CODE_SMALL_LAST);
      g = pin(s1[7:4], `CODE_SMALL_LAST);
      h = pin(s1[3:0], `CODE_SMALL_LAST);
      return {a[15:4], b[15:4], c[15:4], d[15:4], last,
              a[3:0], b[3:0], c[3:0], d[3:0],
              e[15:4], f[15:4], g[15:4], h[15:4]};
   endfunction : note

   // everything the bench compares, in note order
   function automatic logic [119:0] observed();
      return {cmp0_route_o, cmp1_route_o, rdata_o, n0, p0, n1, p1,
              small0_route, small1_route};
   endfunction : observed

   task automatic chk(input string nm, input logic [119:0] e, g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic end_of_test();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_of_test

   // reference registers move when the request is driven; wr+rd reads old
   task automatic op(input logic w, r, input logic [7:0] a, pg, d,
                     input logic en);
      logic hit;
      hit = en && pg == `CMP_SEL_PAGE;
      sfr_i = '{w, r, a, pg, d};
      clk_en_i = en;
      if (en && r) last = !hit ? 8'h00 : a == `CMP0_SEL_ADDR ? s0 :
                          a == `CMP1_SEL_ADDR ? s1 : 8'h00;
      if (hit && w && a == `CMP0_SEL_ADDR) s0 = d;
      if (hit && w && a == `CMP1_SEL_ADDR) s1 = d;
      if (en && (w || r)) q.push_back(note());
      @(posedge clock_i);
      #1;
   endtask : op

   // monitor: every taken request leaves one note, checked a cycle later;
   // a result with no note left is a mismatch, never a pop of nothing
   always @(posedge clock_i) begin : monitor
      logic t;
      t = rst_n_i && clk_en_i && (sfr_i.wr || sfr_i.rd);
      #1;
      if (t && q.size() == 0) begin
         miscompares++;
         $display("Error outputs expected a note seen none");
      end else if (t) begin
         chk("outputs", q.pop_front(), observed());
      end
   end

   initial begin : main
      rst_n_i = 1'b0;
      clk_en_i = 1'b1;
      sfr_i = '0;
      s0 = `CMP_SEL_RESET;
      s1 = `CMP_SEL_RESET;
      last = 8'h00;
      void'($urandom(32'hf258));
      repeat (16) @(posedge clock_i);
      #1 rst_n_i = 1'b1;
      chk("reset", note(), observed());
      // every code in every field, reads back to back with writes
      for (int c = 0; c < 16; c++) begin
         op(1, 0, `CMP0_SEL_ADDR, 8'h00, {4'(c), 4'(15 - c)}, 1);
         op(1, 1, `CMP1_SEL_ADDR, 8'h00, {4'(15 - c), 4'(c)}, 1);
         op(1, 1, `CMP0_SEL_ADDR, 8'h00, {4'(c), 4'(c)}, 1);
      end
      // random traffic, unmapped places and stalled clock enable
      repeat (400) begin
         k = $urandom_range(3);
         op(1'($urandom), 1'($urandom), k == 0 ? `CMP0_SEL_ADDR :
            k == 1 ? `CMP1_SEL_ADDR : 8'($urandom),
            $urandom_range(7) == 0 ? 8'($urandom) : 8'h00, 8'($urandom),
            $urandom_range(5) != 0);
      end
      // drop the strobes so the last request is not taken twice, then a
      // mid-run reset with enable low: writes undone, enable ignored
      sfr_i = '0;
      clk_en_i = 1'b0;
      rst_n_i = 1'b0;
      s0 = `CMP_SEL_RESET;
      s1 = `CMP_SEL_RESET;
      last = 8'h00;
      repeat (2) @(posedge clock_i);
      #1 rst_n_i = 1'b1;
      clk_en_i = 1'b1;
      chk("reset again", note(), observed());
      op(1, 1, `CMP1_SEL_ADDR, 8'h00, 8'h5a, 1);
      sfr_i = '0;
      @(posedge clock_i);
      #2;
      // every note must have met its result
      if (q.size() != 0) begin
         miscompares++;
         $display("Error notes expected 0 seen %0d", q.size());
      end
      end_of_test();
   end
endmodule : test_comparator_input_select
`default_nettype wire
